// ---- shared/flash_ctrl_pkg.sv ----
// Constants shared by the serial flash host-interface control logic.
// Assumes a 200 MHz system clock and a host-driven serial clock.
package flash_ctrl_pkg;
    // Instruction codes
    localparam logic [7:0] OP_QPI_ON = 8'h38;
    localparam logic [7:0] OP_QPI_OFF = 8'hff;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE = 8'hd8;
    localparam logic [7:0] OP_CE = 8'hc7;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_UNLK = 8'h39;
    localparam logic [7:0] OP_PD = 8'hb9;
    localparam logic [7:0] OP_RPD = 8'hab;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_QOUT = 8'h6b;
    localparam logic [7:0] OP_QIO = 8'heb;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SW_CLEAR_NS = 30000;
    localparam int SW_CLEAR_CYC = SW_CLEAR_NS * CLK_MHZ / 1000;
    localparam int HW_CLEAR_NS = 1000;
    localparam int HW_CLEAR_CYC = (HW_CLEAR_NS * CLK_MHZ + 999) / 1000;
    localparam int PUW_NS = 10000;
    localparam int PUW_CYC = PUW_NS * CLK_MHZ / 1000;
    localparam int CNT_W = 16;
    // Serial framing
    localparam logic [5:0] INSTR_BITS = 6'h08;
    localparam logic [5:0] ADDR_END = 6'h20;
    localparam logic [5:0] QUAD_STEP = 6'h04;
    localparam logic [5:0] ONE_STEP = 6'h01;
    // Lock map: 16 bottom sectors, 16 top sectors, 62 inner blocks
    localparam int LOCK_N = 94;
    localparam int BLK_LSB = 16;
    localparam int SEC_LSB = 12;
    localparam logic [5:0] BLK_BOTTOM = 6'h00;
    localparam logic [5:0] BLK_TOP = 6'h3f;
    localparam logic [6:0] TOP_BASE = 7'h10;
    localparam logic [6:0] MID_BASE = 7'h1f;
    // Status byte as shifted out
    localparam int WEL_POS = 1;
    localparam int BUSY_POS = 0;
    localparam logic QE_RST = 1'b0;
    // Pin indices
    localparam int PIN_DI = 0;
    localparam int PIN_DO = 1;
    localparam int PIN_PAUSE = 3;
    // Link-side synchroniser lanes
    localparam int X_QPI = 0;
    localparam int X_QE = 1;
    localparam int X_SEL = 2;
    localparam int X_WEL = 3;
    localparam int X_BUSY = 4;
    localparam int X_N = 5;
    // System-side synchroniser lanes
    localparam int Y_OPC = 0;
    localparam int Y_ADR = 1;
    localparam int Y_HW = 2;
    localparam int Y_N = 3;
endpackage

// ---- hdl/flash_host_ctrl.sv ----
// Host-interface control of a serial flash: modes, pause, resets, write latch, locks.
// Assumes a host SPI controller on the pins and an array engine on the system side.
// Overview of operation
// - Quad reads and four-wire entry need quad_io_enable
// - Four-wire opcode takes two clocks, single eight
// - 38h enters four-wire mode, FFh leaves
// - Power-up and software reset give SPI mode
// - Pause only when quad_io_enable is clear
// - Pause begins on pause_n fall or clock fall; the logic starts it only at a clock fall with pause_n low
// - Pause ends on pause_n rise or clock fall; the logic ends it at a clock fall with pause_n high, or at once when chip select goes high
// - While paused: output off, input frozen, state kept
// - 66h then 99h resets; commands refused meanwhile
// - Select bit picks pause_n or hw_clear_n
// - hw_clear_n low 1us restores power-on state
// - quad_io_enable disables pause and hardware reset
// - Hardware reset overrides every other input
// - Write commands refused during power-up delay
// - Write latch needed before program or erase
// - Completion clears write_latch_bit
// - Power-down ignores all but release; the logic still answers 05h status reads
// - One lock per inner block and edge sector
// - Locks all set at power-on; 39h clears one
// - Scheme select picks block-protect or lock bits
// - Write enable sets write_latch_bit
// - quad_io_enable kept as a stored status bit
`timescale 1ns/1ps
module flash_host_ctrl #(
    parameter int SW_CLEAR_CYC_P = flash_ctrl_pkg::SW_CLEAR_CYC // Software clear duration
)(
    input wire logic clk_in, // System clock, 200 MHz
    input wire logic rst_in, // Power-on reset, async, high
    input wire logic sclk_in, // Serial clock from host
    input wire logic cs_n_in, // Chip select, active low
    input wire logic [3:0] io_in, // Data pins, read side
    output logic [3:0] io_out_out, // Data pins, drive value
    output logic [3:0] io_oe_out, // Data pins, drive enable
    input wire logic qe_load_in, // Pulse: store qe_value_in
    input wire logic qe_value_in, // New quad_io_enable value
    input wire logic pause_or_clear_select_in, // 0 pause_n, 1 hw_clear_n
    input wire logic protect_scheme_select_in, // 0 block-protect, 1 lock bits
    input wire logic bp_protected_in, // Block-protect decoder hit
    input wire logic array_done_in, // Pulse: program/erase finished
    input wire logic array_busy_in, // Array engine busy
    output logic quad_io_enable_out, // Stored quad_io_enable
    output logic four_wire_command_mode_out, // Four-wire command mode active
    output logic write_latch_bit_out, // Write enable latch
    output logic power_down_out, // Power-down active
    output logic clearing_out, // Reset to power-on state in force
    output logic array_start_out, // Pulse: start array operation
    output logic [7:0] array_op_out, // Operation code for the engine
    output logic [23:0] array_addr_out // Operation address
);
    import flash_ctrl_pkg::*;

    // Maps an address to its lock bit: edge blocks per sector, others per block
    function automatic logic [6:0] lock_idx(input logic [23:0] a);
        logic [5:0] b;
        b = a[BLK_LSB+:6];
        if (b == BLK_BOTTOM)
            lock_idx = {3'h0, a[SEC_LSB+:4]};
        else if (b == BLK_TOP)
            lock_idx = TOP_BASE + {3'h0, a[SEC_LSB+:4]};
        else
            lock_idx = MID_BASE + {1'b0, b};
    endfunction

    // Link domain state
    logic link_rst; // Chip select high clears frame state
    logic [X_N-1:0] lsy1_ff; // First sync stage
    logic [X_N-1:0] lsy2_ff; // Second sync stage
    logic [31:0] sh_ff; // Incoming bits
    logic [5:0] cnt_ff; // Bits received this frame
    logic [31:0] nxt_sh;
    logic [5:0] nxt_cnt;
    logic step; // A bit group is taken this edge
    logic [7:0] opc_l_ff; // Last opcode, stable after toggle
    logic [23:0] adr_l_ff; // Last address, stable after toggle
    logic opc_tg_ff; // Toggles per opcode
    logic adr_tg_ff; // Toggles per address
    logic rd_ff; // Status read in progress
    logic hold_ff; // Pause in force
    logic nxt_hold; // Pause wanted at this falling edge
    logic [7:0] st_ff; // Status shifter
    logic [3:0] io_out_ff;
    logic [3:0] io_oe_ff;
    logic qpi_l, qe_l, pause_en_l;

    // System domain state
    logic [Y_N-1:0] s1_ff, s2_ff; // Two-stage synchroniser
    logic [1:0] tg3_ff; // Previous toggle values
    logic opc_ev, adr_ev; // One-cycle events
    logic qe_ff, qpi_ff, wel_ff, pd_ff, start_ff, rst_en_ff, init_ff;
    logic [7:0] op_ff;
    logic [23:0] addr_ff;
    logic [LOCK_N-1:0] locks_ff;
    logic [CNT_W-1:0] sw_cnt_ff, hw_cnt_ff, puw_cnt_ff;
    logic hw_en, hw_low, blocked, init, puw_done, accept, adr_ok;
    logic wel_set, sw_go, prot_hit;

    assign link_rst = rst_in | cs_n_in;
    assign qpi_l = lsy2_ff[X_QPI];
    assign qe_l = lsy2_ff[X_QE];
    // Shared pin pauses only with quad off and pause role chosen
    assign pause_en_l = !qe_l && !lsy2_ff[X_SEL];
    // Pause request from the shared pin, dead when the pin is not a pause input
    assign nxt_hold = pause_en_l && !io_in[PIN_PAUSE];

    // Carry mode and status bits into the link clock; stays put between frames
    always_ff @(posedge sclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lsy1_ff <= '0;
            lsy2_ff <= '0;
        end
        else
        begin
            lsy1_ff <= {array_busy_in | (sw_cnt_ff != '0), wel_ff,
                        pause_or_clear_select_in, qe_ff, qpi_ff};
            lsy2_ff <= lsy1_ff;
        end
    end

    // Next shift value: four lines per clock in four-wire mode, else one
    always_comb
    begin
        step = !hold_ff && (cnt_ff != ADDR_END);
        nxt_cnt = cnt_ff + (qpi_l ? QUAD_STEP : ONE_STEP);
        nxt_sh = qpi_l ? {sh_ff[27:0], io_in} : {sh_ff[30:0], io_in[PIN_DI]};
    end

    // Frame shifter, cleared whenever the host deselects
    always_ff @(posedge sclk_in or posedge link_rst)
    begin
        if (link_rst)
        begin
            sh_ff <= '0;
            cnt_ff <= '0;
            rd_ff <= 1'b0;
        end
        else if (step)
        begin
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            if (nxt_cnt == INSTR_BITS && nxt_sh[7:0] == OP_RDSR)
                rd_ff <= 1'b1;
        end
    end

    // Opcode and address hand-off; toggles survive deselect so no event is lost
    always_ff @(posedge sclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            opc_l_ff <= '0;
            adr_l_ff <= '0;
            opc_tg_ff <= 1'b0;
            adr_tg_ff <= 1'b0;
        end
        else if (step && !cs_n_in)
        begin
            if (nxt_cnt == INSTR_BITS)
            begin
                opc_l_ff <= nxt_sh[7:0];
                opc_tg_ff <= ~opc_tg_ff;
            end
            if (nxt_cnt == ADDR_END)
            begin
                adr_l_ff <= nxt_sh[23:0];
                adr_tg_ff <= ~adr_tg_ff;
            end
        end
    end

    // Pause and output on the falling clock edge; the pin is sampled at the
    // fall, so a pause taken while the clock is low shows at the next fall
    always_ff @(negedge sclk_in or posedge link_rst)
    begin
        if (link_rst)
        begin
            hold_ff <= 1'b0;
            st_ff <= '0;
            io_out_ff <= '0;
            io_oe_ff <= '0;
        end
        else
        begin
            hold_ff <= nxt_hold;
            // Quiet from the fall that starts the pause, so no status bit is lost
            if (nxt_hold)
                io_oe_ff <= '0;
            else if (rd_ff)
            begin
                io_oe_ff <= 4'h2;
                io_out_ff[PIN_DO] <= st_ff[7];
                st_ff <= {st_ff[6:0], st_ff[7]};
            end
            else
            begin
                st_ff <= '0;
                st_ff[WEL_POS] <= lsy2_ff[X_WEL];
                st_ff[BUSY_POS] <= lsy2_ff[X_BUSY];
            end
        end
    end

    // Bring link toggles and the shared reset pin into the system clock
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            tg3_ff <= '0;
        end
        else
        begin
            s1_ff <= {io_in[PIN_PAUSE], adr_tg_ff, opc_tg_ff};
            s2_ff <= s1_ff;
            tg3_ff <= s2_ff[Y_ADR:Y_OPC];
        end
    end

    // Command qualification
    always_comb
    begin
        opc_ev = s2_ff[Y_OPC] ^ tg3_ff[Y_OPC];
        adr_ev = s2_ff[Y_ADR] ^ tg3_ff[Y_ADR];
        hw_en = pause_or_clear_select_in && !qe_ff;
        hw_low = hw_en && !s2_ff[Y_HW];
        init = (hw_cnt_ff == CNT_W'(HW_CLEAR_CYC)) || (sw_cnt_ff == CNT_W'(1));
        blocked = hw_low || (sw_cnt_ff != '0);
        puw_done = (puw_cnt_ff == CNT_W'(PUW_CYC));
        accept = opc_ev && !blocked && (!pd_ff || opc_l_ff == OP_RPD);
        adr_ok = adr_ev && !blocked && !pd_ff;
        wel_set = accept && opc_l_ff == OP_WREN && puw_done;
        sw_go = accept && rst_en_ff && opc_l_ff == OP_RST;
        prot_hit = protect_scheme_select_in ? locks_ff[lock_idx(adr_l_ff)]
                                            : bp_protected_in;
    end

    // Power-up write delay counter
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            puw_cnt_ff <= '0;
        else if (!puw_done)
            puw_cnt_ff <= puw_cnt_ff + CNT_W'(1);
    end

    // Hardware clear: count low time, saturate at the threshold
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            hw_cnt_ff <= '0;
        else if (!hw_low)
            hw_cnt_ff <= '0;
        else if (hw_cnt_ff != CNT_W'(HW_CLEAR_CYC))
            hw_cnt_ff <= hw_cnt_ff + CNT_W'(1);
    end

    // Software clear: arm on 66h, run on 99h straight after
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rst_en_ff <= 1'b0;
            sw_cnt_ff <= '0;
        end
        else
        begin
            if (accept)
                rst_en_ff <= (opc_l_ff == OP_RST_EN);
            if (hw_low)
                sw_cnt_ff <= '0;
            else if (sw_go)
                sw_cnt_ff <= CNT_W'(SW_CLEAR_CYC_P);
            else if (sw_cnt_ff != '0)
                sw_cnt_ff <= sw_cnt_ff - CNT_W'(1);
        end
    end

    // Stored quad enable; cannot be dropped while in four-wire mode
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            qe_ff <= QE_RST;
        else if (qe_load_in && (qe_value_in || !qpi_ff))
            qe_ff <= qe_value_in;
    end

    // Mode select: exactly one of SPI and four-wire command mode
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            qpi_ff <= 1'b0;
        else if (init)
            qpi_ff <= 1'b0;
        else if (accept && opc_l_ff == OP_QPI_ON && qe_ff)
            qpi_ff <= 1'b1;
        else if (accept && opc_l_ff == OP_QPI_OFF)
            qpi_ff <= 1'b0;
    end

    // Write latch: set wins over a completion in the same cycle
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            wel_ff <= 1'b0;
        else if (init)
            wel_ff <= 1'b0;
        else if (wel_set)
            wel_ff <= 1'b1;
        else if (array_done_in || (accept && opc_l_ff == OP_WRDI))
            wel_ff <= 1'b0;
    end

    // Power-down
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            pd_ff <= 1'b0;
        else if (init)
            pd_ff <= 1'b0;
        else if (accept && opc_l_ff == OP_PD)
            pd_ff <= 1'b1;
        else if (accept && opc_l_ff == OP_RPD)
            pd_ff <= 1'b0;
    end

    // Individual locks: all set at power-on, 39h clears one
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            locks_ff <= '1;
        else if (init)
            locks_ff <= '1;
        else if (adr_ok && opc_l_ff == OP_UNLK)
            locks_ff[lock_idx(adr_l_ff)] <= 1'b0;
    end

    // Array start requests: writes gated by latch and delay, program and erase also by protection, quad reads by quad enable
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            start_ff <= 1'b0;
            op_ff <= '0;
            addr_ff <= '0;
            init_ff <= 1'b0;
        end
        else
        begin
            init_ff <= init;
            start_ff <= 1'b0;
            if (adr_ok && (opc_l_ff == OP_PP || opc_l_ff == OP_SE || opc_l_ff == OP_BE))
                start_ff <= wel_ff && puw_done && !prot_hit;
            else if (adr_ok && (opc_l_ff == OP_QOUT || opc_l_ff == OP_QIO))
                start_ff <= qe_ff;
            else if (accept && opc_l_ff == OP_CE)
                start_ff <= wel_ff && puw_done && (protect_scheme_select_in
                            ? !(|locks_ff) : !bp_protected_in);
            else if (accept && opc_l_ff == OP_WRSR)
                start_ff <= wel_ff && puw_done;
            if (opc_ev || adr_ev)
            begin
                op_ff <= opc_l_ff;
                addr_ff <= adr_l_ff;
            end
        end
    end

    assign io_out_out = io_out_ff;
    assign io_oe_out = io_oe_ff;
    assign quad_io_enable_out = qe_ff;
    assign four_wire_command_mode_out = qpi_ff;
    assign write_latch_bit_out = wel_ff;
    assign power_down_out = pd_ff;
    assign clearing_out = init_ff;
    assign array_start_out = start_ff;
    assign array_op_out = op_ff;
    assign array_addr_out = addr_ff;

    // Checks
    property p_qpi_qe;
        @(posedge clk_in) disable iff (rst_in) qpi_ff |-> qe_ff;
    endproperty
    a_qpi_qe: assert property (p_qpi_qe) else $error("four-wire mode without quad");
    property p_init_spi;
        @(posedge clk_in) disable iff (rst_in) init |=> !qpi_ff && &locks_ff;
    endproperty
    a_init_spi: assert property (p_init_spi) else $error("clear left mode or locks");
    property p_sw_load;
        @(posedge clk_in) disable iff (rst_in)
            (sw_go && !hw_low) |=> sw_cnt_ff == CNT_W'(SW_CLEAR_CYC_P) && blocked;
    endproperty
    a_sw_load: assert property (p_sw_load) else $error("software clear not started");
    property p_blocked;
        @(posedge clk_in) disable iff (rst_in) blocked |=> !start_ff && !$rose(wel_ff);
    endproperty
    a_blocked: assert property (p_blocked) else $error("command taken while clearing");
    property p_puw;
        @(posedge clk_in) disable iff (rst_in)
            !puw_done |-> !wel_ff && !(start_ff && op_ff != OP_QOUT && op_ff != OP_QIO);
    endproperty
    a_puw: assert property (p_puw) else $error("write before power-up delay");
    property p_wel;
        @(posedge clk_in) disable iff (rst_in)
            (wel_set && !init) |=> wel_ff ##1 (wel_ff || $past(array_done_in));
    endproperty
    a_wel: assert property (p_wel) else $error("write enable not latched");
    property p_done;
        @(posedge clk_in) disable iff (rst_in) (array_done_in && !wel_set) |=> !wel_ff;
    endproperty
    a_done: assert property (p_done) else $error("latch kept after completion");
    property p_pd;
        @(posedge clk_in) disable iff (rst_in) pd_ff |=> !start_ff;
    endproperty
    a_pd: assert property (p_pd) else $error("operation started in power-down");
    property p_hw;
        @(posedge clk_in) disable iff (rst_in)
            hw_cnt_ff == CNT_W'(HW_CLEAR_CYC) |=> clearing_out && !wel_ff && !qpi_ff;
    endproperty
    a_hw: assert property (p_hw) else $error("hardware clear had no effect");
    property p_pause;
        @(negedge sclk_in) disable iff (link_rst) hold_ff |-> io_oe_ff == '0;
    endproperty
    a_pause: assert property (p_pause) else $error("output driven while paused");
    property p_step;
        @(posedge sclk_in) disable iff (link_rst)
            (step && qpi_l) |=> cnt_ff == $past(cnt_ff) + QUAD_STEP;
    endproperty
    a_step: assert property (p_step) else $error("four-wire step not four bits");
endmodule

// ---- tb/spi_host_model.sv ----
// Host serial master model: chip select, serial clock and the four pins.
// Assumes the bench calls frame() and sets pin3 and qm directly.
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk_out, // Serial clock, low between frames apart from two idle clocks before each
    output logic cs_n_out, // Chip select, active low
    output logic [3:0] io_wire_out, // Resolved pin levels
    input wire logic [3:0] dev_io_in, // Device drive values
    input wire logic [3:0] dev_oe_in // Device drive enables
);
    logic [3:0] drv = 4'h5; // Host drive values
    logic pin3 = 1'h1; // Pause or clear pin in single-line framing
    logic qm = 1'h0; // Four-wire framing in use
    initial
    begin
        sclk_out = 1'h0;
        cs_n_out = 1'h1;
    end
    // Device wins where it drives; pin 3 is a control input unless quad
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            io_wire_out[b] = dev_oe_in[b] ? dev_io_in[b] : drv[b];
        if (!qm && !dev_oe_in[3])
            io_wire_out[3] = pin3;
    end
    // Frame of wr write steps then rd_n read steps; pauses after step hold_at
    task automatic frame(input logic [31:0] bits, input int wr, input int rd_n,
        input int hold_at, output logic [7:0] rd);
        rd = 8'h0;
        // Two idle clocks let a mode change reach the link side
        repeat (2)
        begin
            #7.5 sclk_out = 1'h1;
            #7.5 sclk_out = 1'h0;
        end
        cs_n_out = 1'h0;
        for (int i = 0; i < wr + rd_n; i++)
        begin
            if (i < wr)
                drv = qm ? bits[31 - 4 * i -: 4] : {~drv[3:1], bits[31 - i]};
            else
                drv = ~drv;
            #7.5 rd = {rd[6:0], io_wire_out[1]};
            sclk_out = 1'h1;
            // Pin falls with clock high, so the pause starts at the next fall
            #2 if (i == hold_at) pin3 = 1'h0;
            #5.5 sclk_out = 1'h0;
            if (i == hold_at)
            begin
                // Garbage clocks and data that a paused device must ignore
                repeat (3)
                begin
                    drv = ~drv;
                    #7.5 sclk_out = 1'h1;
                    #7.5 sclk_out = 1'h0;
                end
                drv = ~drv;
                #7.5 sclk_out = 1'h1;
                #2 pin3 = 1'h1;
                #5.5 sclk_out = 1'h0;
            end
        end
        #7.5 cs_n_out = 1'h1;
        drv = ~drv; // Released lines no longer show the last bit
    endtask
endmodule

// ---- tb/tb_flash_host_ctrl.sv ----
// Self-checking bench for the flash host-interface control block.
// Assumes the package and host model are compiled first.
`timescale 1ns/1ps
module tb_flash_host_ctrl;
    import flash_ctrl_pkg::*;
    localparam int SWC = 20; // Short software clear keeps the run brief
    logic clk_in = 1'h0; // System clock
    logic rst_in = 1'h1; // Power-on reset
    logic sclk, cs_n; // Link from host model
    logic [3:0] io_wire, io_out_out, io_oe_out; // Pins and device drive
    logic qe_load_in = 1'h0, qe_value_in = 1'h0, sel = 1'h0, scheme = 1'h0; // Config
    logic bp = 1'h0, done = 1'h0, busy = 1'h0; // Array side
    logic qe, four_wire_command_mode, write_latch_bit, pd, clr, start; // Device status
    logic [7:0] aop, rd;
    logic [23:0] aadr;
    int n_fail = 0, cmp_count = 0, n_start = 0, cycles = 0;
    spi_host_model spi_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .io_wire_out(io_wire),
        .dev_io_in(io_out_out), .dev_oe_in(io_oe_out));
    flash_host_ctrl #(.SW_CLEAR_CYC_P(SWC)) flash_host_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io_wire), .io_out_out(io_out_out),
        .io_oe_out(io_oe_out), .qe_load_in(qe_load_in), .qe_value_in(qe_value_in),
        .pause_or_clear_select_in(sel), .protect_scheme_select_in(scheme),
        .bp_protected_in(bp), .array_done_in(done), .array_busy_in(busy),
        .quad_io_enable_out(qe), .four_wire_command_mode_out(four_wire_command_mode), .write_latch_bit_out(write_latch_bit),
        .power_down_out(pd), .clearing_out(clr), .array_start_out(start),
        .array_op_out(aop), .array_addr_out(aadr));
    initial
        forever #2.5 clk_in = ~clk_in;
    // Counts start pulses at the falling edge, where they stand settled; the ceiling cuts a hang
    always @(negedge clk_in)
    begin
        cycles++;
        if (start === 1'h1)
            n_start++;
        if (cycles == 20000)
        begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Whole frame, then time for the opcode to cross to the system side
    task automatic op(input logic [7:0] c, input logic [23:0] a = 24'h0, input int n = 8);
        spi_host_model_i.frame({c, a}, n, 0, -1, rd);
        cyc(12);
    endtask
    // Any command; exp is the number of start pulses it should raise
    task automatic run(input logic [7:0] c, input logic [23:0] a, input int n,
        input logic [31:0] exp);
        int s;
        s = n_start;
        op(c, a, n);
        chk("array start", exp, n_start - s);
    endtask
    // Page program through the same count
    task automatic pp(input logic [23:0] a, input logic [31:0] exp);
        run(OP_PP, a, 32, exp);
    endtask
    task automatic pulse_done();
        done = 1'h1;
        cyc(1);
        done = 1'h0;
        cyc(3);
        chk("latch after done", 1'h0, write_latch_bit);
    endtask
    task automatic load_qe(input logic v);
        qe_value_in = v;
        qe_load_in = 1'h1;
        cyc(1);
        qe_load_in = 1'h0;
        cyc(4);
        chk("quad enable", v, qe);
    endtask
    initial
    begin
        cyc(4);
        rst_in = 1'h0;
        cyc(2);
        chk("quad enable", 1'h0, qe);
        chk("four-wire mode", 1'h0, four_wire_command_mode);
        chk("write latch", 1'h0, write_latch_bit);
        op(OP_WREN);
        chk("early write enable", 1'h0, write_latch_bit);
        cyc(PUW_CYC);
        op(OP_WREN);
        chk("write enable", 1'h1, write_latch_bit);
        busy = 1'h1;
        spi_host_model_i.frame({OP_RDSR, 24'h0}, 8, 8, -1, rd);
        busy = 1'h0;
        chk("status byte", 8'h03, rd);
        $display("test power-up done");
        scheme = 1'h1;
        pp(24'h030000, 32'h0);
        op(OP_UNLK, 24'h030000, 32);
        run(OP_BE, 24'h000000, 32, 32'h0);
        pp(24'h030000, 32'h1);
        chk("array op", OP_PP, aop);
        chk("array addr", 24'h030000, aadr);
        pulse_done();
        pp(24'h030000, 32'h0);
        op(OP_WREN);
        op(OP_UNLK, 24'h3f1000, 32);
        pp(24'h3f2000, 32'h0);
        run(OP_SE, 24'h3f1000, 32, 32'h1);
        pulse_done();
        op(OP_WREN);
        scheme = 1'h0;
        bp = 1'h1;
        pp(24'h030000, 32'h0);
        bp = 1'h0;
        pp(24'h030000, 32'h1);
        pulse_done();
        run(OP_WRSR, 24'h0, 8, 32'h0);
        op(OP_WREN);
        run(OP_CE, 24'h0, 8, 32'h1);
        pulse_done();
        $display("test protection done");
        op(OP_QPI_ON);
        chk("four-wire without quad", 1'h0, four_wire_command_mode);
        run(OP_QOUT, 24'h0, 32, 32'h0);
        load_qe(1'h1);
        run(OP_QIO, 24'h0, 32, 32'h1);
        op(OP_QPI_ON);
        chk("four-wire entry", 1'h1, four_wire_command_mode);
        spi_host_model_i.qm = 1'h1;
        op(OP_WREN, 24'h0, 2);
        chk("quad write enable", 1'h1, write_latch_bit);
        op(OP_QPI_OFF, 24'h0, 2);
        chk("four-wire exit", 1'h0, four_wire_command_mode);
        spi_host_model_i.qm = 1'h0;
        sel = 1'h1;
        spi_host_model_i.pin3 = 1'h0;
        cyc(300);
        chk("clear pin with quad", 1'h0, clr);
        chk("latch with quad", 1'h1, write_latch_bit);
        spi_host_model_i.pin3 = 1'h1;
        sel = 1'h0;
        op(OP_RST_EN);
        op(OP_RDSR);
        op(OP_RST);
        chk("disarmed reset", 1'h1, write_latch_bit);
        op(OP_QPI_ON);
        spi_host_model_i.qm = 1'h1;
        op(OP_RST_EN, 24'h0, 2);
        spi_host_model_i.frame({OP_RST, 24'h0}, 2, 0, -1, rd);
        for (int k = 0; k < 200 && clr !== 1'h1; k++)
            cyc(1);
        chk("software clear", 1'h1, clr);
        cyc(3);
        chk("mode after clear", 1'h0, four_wire_command_mode);
        chk("latch after clear", 1'h0, write_latch_bit);
        spi_host_model_i.qm = 1'h0;
        load_qe(1'h0);
        $display("test modes done");
        op(OP_PD);
        chk("power down", 1'h1, pd);
        op(OP_WREN);
        chk("latch in power down", 1'h0, write_latch_bit);
        op(OP_RPD);
        chk("power down release", 1'h0, pd);
        spi_host_model_i.frame({OP_WREN, 24'h0}, 4, 0, -1, rd);
        cyc(12);
        chk("partial frame", 1'h0, write_latch_bit);
        spi_host_model_i.frame({OP_WREN, 24'h0}, 8, 0, 3, rd);
        cyc(12);
        chk("paused frame", 1'h1, write_latch_bit);
        spi_host_model_i.frame({OP_RDSR, 24'h0}, 8, 8, 10, rd);
        chk("paused status", 8'h02, rd);
        sel = 1'h1;
        spi_host_model_i.pin3 = 1'h0;
        cyc(150);
        chk("short clear pulse", 1'h0, clr);
        cyc(100);
        chk("hardware clear", 1'h1, clr);
        chk("latch after hardware clear", 1'h0, write_latch_bit);
        spi_host_model_i.pin3 = 1'h1;
        cyc(5);
        chk("clear released", 1'h0, clr);
        $display("test resets done");
        final_report();
    end
endmodule
